//--- design/mdi_host.sv
// Host controller that drives a multiplexed-address 16K x 1 dynamic memory
// Functional notes
// - The 14-bit address goes out on seven pins, row half then column.
// - The column strobe may fall once row hold is met and pins show column.
// - Page mode keeps the row strobe low across column cycles of one row.
// - Page mode works for read, write and read-modify-write.
// - Early write: enable low first, data valid at column strobe fall.
// - Late data or read-modify-write delays write enable; data meets it. Only RMW delays it here; every write is early.
// - Every one of 128 rows is refreshed each 2 ms, row strobe alone.
// - Eight refresh cycles run after power-up before normal use.
`timescale 1ns/100ps

module mdi_host (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      rstn,
  // User request port
  input  wire logic                      reqValid,
  input  wire mdi_pkg::mdi_req_t         req,
  output      logic                      reqReady,
  output      logic                      rspValid,
  output      logic                      rspData,
  output      logic                      initDone,
  // Memory pins
  output      mdi_pkg::mdi_pins_t        pins,
  input  wire logic                      memQ
);

  // ----------------------------------------------------------------------
  // Pin synchroniser for the data output of the memory
  // ----------------------------------------------------------------------
  logic qMeta_q;
  logic qSync_q;

  // Two stages before any logic looks at the memory output
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      qMeta_q <= 1'b0;
      qSync_q <= 1'b0;
    end else begin
      qMeta_q <= memQ;
      qSync_q <= qMeta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Controller state
  // ----------------------------------------------------------------------
  mdi_pkg::mdi_state_t                    state_q, state_d;
  logic [mdi_pkg::CNT_W-1:0]              cnt_q, cnt_d;
  logic [mdi_pkg::CNT_W-1:0]              refTmr_q, refTmr_d;
  logic                                   refDue_q, refDue_d;
  logic [mdi_pkg::ROW_BITS-1:0]           refRow_q, refRow_d;
  logic [3:0]                             warm_q, warm_d;
  logic [mdi_pkg::ROW_BITS-1:0]           openRow_q, openRow_d;
  mdi_pkg::mdi_req_t                      cur_q, cur_d;
  mdi_pkg::mdi_pins_t                     pins_q, pins_d;
  logic                                   ready_q, ready_d;
  logic                                   rspV_q, rspV_d;
  logic                                   rspD_q, rspD_d;
  logic                                   init_q, init_d;
  logic                                   pend_q, pend_d;

  // Row and column halves of a full address
  function automatic logic [mdi_pkg::ROW_BITS-1:0] rowOf(
    input logic [mdi_pkg::ADDR_BITS-1:0] a);
    rowOf = a[mdi_pkg::ROW_POS +: mdi_pkg::ROW_BITS];
  endfunction

  function automatic logic [mdi_pkg::COL_BITS-1:0] colOf(
    input logic [mdi_pkg::ADDR_BITS-1:0] a);
    colOf = a[mdi_pkg::COL_POS +: mdi_pkg::COL_BITS];
  endfunction

  // Next-state logic for strobes, refresh and requests
  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    refTmr_d  = refTmr_q;
    refDue_d  = refDue_q;
    refRow_d  = refRow_q;
    warm_d    = warm_q;
    openRow_d = openRow_q;
    cur_d     = cur_q;
    pins_d    = pins_q;
    ready_d   = 1'b0;
    rspV_d    = 1'b0;
    rspD_d    = rspD_q;
    init_d    = init_q;
    pend_d    = pend_q;

    // Refresh pacing: one row per interval, so 128 rows per 2 ms
    if (refTmr_q == CNT_W_INTERVAL()) begin
      refTmr_d = mdi_pkg::CNT_ZERO;
      refDue_d = 1'b1;
    end else begin
      refTmr_d = refTmr_q + 12'h001;
    end

    case (state_q)
      mdi_pkg::S_IDLE: begin
        pins_d.rasN = 1'b1;
        pins_d.casN = 1'b1;
        pins_d.weN  = 1'b1;
        // A request seen with ready high is always taken; refresh waits
        if (reqValid && ready_q) begin
          cur_d       = req;
          pins_d.addr = rowOf(req.addr);
          state_d     = mdi_pkg::S_ROW;
        end else if (!init_q || refDue_q) begin
          // Row address set up now, strobe falls next cycle
          pins_d.addr = refRow_q;
          cnt_d       = 12'(mdi_pkg::RAS_PRE_CYC);
          state_d     = mdi_pkg::S_REF;
          // A due flag raised this same cycle survives the clear
          if (refTmr_q != CNT_W_INTERVAL()) begin
            refDue_d = 1'b0;
          end
        end else begin
          ready_d = 1'b1;
        end
      end
      mdi_pkg::S_REF: begin
        if (cnt_q == mdi_pkg::CNT_ZERO) begin
          pins_d.rasN = 1'b1;
          refRow_d    = refRow_q + 7'h01;
          if (!init_q) begin
            warm_d = warm_q + 4'h1;
            if (warm_q == 4'(mdi_pkg::WARMUP_CYCLES - 1)) begin
              init_d = 1'b1;
            end
          end
          cnt_d   = 12'(mdi_pkg::RAS_PRE_CYC);
          state_d = mdi_pkg::S_PRE;
        end else begin
          pins_d.rasN = 1'b0;                     // Row strobe only
          cnt_d       = cnt_q - 12'h001;
        end
      end
      mdi_pkg::S_ROW: begin
        // Row address was set up last cycle; drop the row strobe
        pins_d.rasN = 1'b0;
        openRow_d   = rowOf(cur_q.addr);
        cnt_d       = 12'(mdi_pkg::RCD_CYC);
        state_d     = mdi_pkg::S_RCD;
      end
      mdi_pkg::S_RCD: begin
        // Row hold met: swap pins to the column half
        pins_d.addr = colOf(cur_q.addr);
        pins_d.dataOut = cur_q.wdata;
        if (cur_q.op == mdi_pkg::MDI_OP_WRITE) begin
          pins_d.weN = 1'b0;                      // Early write
        end
        if (cnt_q == mdi_pkg::CNT_ZERO) begin
          state_d = mdi_pkg::S_CAS;
        end else begin
          cnt_d = cnt_q - 12'h001;
        end
      end
      mdi_pkg::S_CAS: begin
        // Column strobe falls two cycles after the column address
        pins_d.casN = 1'b0;
        cnt_d       = 12'(mdi_pkg::CAS_CYC + 2);
        state_d     = mdi_pkg::S_WLATE;
      end
      mdi_pkg::S_WLATE: begin
        // Hold column strobe long enough for access plus sync delay
        if (cur_q.op == mdi_pkg::MDI_OP_RMW &&
            cnt_q == 12'(mdi_pkg::CAS_CYC + 2 - mdi_pkg::WE_LAG_CYC -
                         1)) begin
          pins_d.weN = 1'b0;                      // Delayed write
        end
        if (cnt_q == mdi_pkg::CNT_ZERO) begin
          // Read data captured while the column strobe is still low
          if (cur_q.op != mdi_pkg::MDI_OP_WRITE) begin
            rspD_d = qSync_q;
          end
          rspV_d      = 1'b1;
          pins_d.casN = 1'b1;
          pins_d.weN  = 1'b1;
          state_d     = mdi_pkg::S_END;
        end else begin
          cnt_d = cnt_q - 12'h001;
        end
      end
      mdi_pkg::S_END: begin
        // Page mode stays on the open row
        if (cur_q.keepRow && !refDue_q) begin
          state_d = mdi_pkg::S_OPEN;
          ready_d = 1'b1;
        end else begin
          pins_d.rasN = 1'b1;
          cnt_d       = 12'(mdi_pkg::RAS_PRE_CYC);
          state_d     = mdi_pkg::S_PRE;
        end
      end
      mdi_pkg::S_OPEN: begin
        // A request seen with ready high is always taken
        if (reqValid && ready_q) begin
          cur_d = req;
          if (rowOf(req.addr) == openRow_q) begin
            // Same row needs no new row address
            pins_d.addr = colOf(req.addr);
            cnt_d       = mdi_pkg::CNT_ZERO;
            state_d     = mdi_pkg::S_RCD;
          end else begin
            // Other row: close this one, open it after precharge
            pins_d.rasN = 1'b1;
            pend_d      = 1'b1;
            cnt_d       = 12'(mdi_pkg::RAS_PRE_CYC);
            state_d     = mdi_pkg::S_PRE;
          end
        end else if (refDue_q) begin
          pins_d.rasN = 1'b1;
          cnt_d       = 12'(mdi_pkg::RAS_PRE_CYC);
          state_d     = mdi_pkg::S_PRE;
        end else begin
          ready_d = 1'b1;
        end
      end
      mdi_pkg::S_PRE: begin
        // Row precharge before the next row strobe
        if (cnt_q == mdi_pkg::CNT_ZERO) begin
          if (pend_q) begin
            // Deferred page-miss request opens its own row now
            pins_d.addr = rowOf(cur_q.addr);
            pend_d      = 1'b0;
            state_d     = mdi_pkg::S_ROW;
          end else begin
            state_d = mdi_pkg::S_IDLE;
          end
        end else begin
          cnt_d = cnt_q - 12'h001;
        end
      end
      default: begin
        state_d = mdi_pkg::S_IDLE;
      end
    endcase
  end

  // Interval length as a counter-wide constant
  function automatic logic [mdi_pkg::CNT_W-1:0] CNT_W_INTERVAL();
    CNT_W_INTERVAL = 12'(mdi_pkg::REF_INTERVAL_CYC - 1);
  endfunction

  // Register stage; strobes idle high out of reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q   <= mdi_pkg::S_IDLE;
      cnt_q     <= mdi_pkg::CNT_ZERO;
      refTmr_q  <= mdi_pkg::CNT_ZERO;
      refDue_q  <= 1'b0;
      refRow_q  <= 7'h00;
      warm_q    <= 4'h0;
      openRow_q <= 7'h00;
      cur_q     <= '0;
      pins_q    <= '{rasN: 1'b1, casN: 1'b1, weN: 1'b1,
                     addr: 7'h00, dataOut: 1'b0};
      ready_q   <= 1'b0;
      rspV_q    <= 1'b0;
      rspD_q    <= 1'b0;
      init_q    <= 1'b0;
      pend_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      refTmr_q  <= refTmr_d;
      refDue_q  <= refDue_d;
      refRow_q  <= refRow_d;
      warm_q    <= warm_d;
      openRow_q <= openRow_d;
      cur_q     <= cur_d;
      pins_q    <= pins_d;
      ready_q   <= ready_d;
      rspV_q    <= rspV_d;
      rspD_q    <= rspD_d;
      init_q    <= init_d;
      pend_q    <= pend_d;
    end
  end

  // Outputs straight from flip-flops
  assign pins     = pins_q;
  assign reqReady = ready_q;
  assign rspValid = rspV_q;
  assign rspData  = rspD_q;
  assign initDone = init_q;

endmodule

//--- design/mdi_pkg.sv
// Package: types, states and timing constants for the DRAM host controller
package mdi_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int unsigned ROW_BITS   = 7;
  localparam int unsigned COL_BITS   = 7;
  localparam int unsigned ADDR_BITS  = ROW_BITS + COL_BITS;
  localparam int unsigned NUM_ROWS   = 128;
  localparam int unsigned ROW_POS    = COL_BITS;  // Row half in upper bits
  localparam int unsigned COL_POS    = 0;

  // ----------------------------------------------------------------------
  // Timing, printed units then cycles at 25 MHz
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_NS          = 40;
  localparam int unsigned REFRESH_MS      = 2;
  // Longest time: round down, spread over all rows
  localparam int unsigned REF_INTERVAL_CYC =
    (REFRESH_MS * 1000000 / CLK_NS) / NUM_ROWS;
  localparam int unsigned WARMUP_CYCLES   = 8;
  // Strobe phase widths in cycles (chosen, plain defaults)
  localparam int unsigned RAS_PRE_CYC     = 2;
  localparam int unsigned RCD_CYC         = 1;
  localparam int unsigned CAS_CYC         = 2;
  localparam int unsigned WE_LAG_CYC      = 1;
  localparam int unsigned CNT_W           = 12;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 12'h000;

  // ----------------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MDI_OP_READ  = 2'h0,
    MDI_OP_WRITE = 2'h1,  // Early write
    MDI_OP_RMW   = 2'h2   // Read, then delayed write
  } mdi_op_t;

  typedef struct packed {
    mdi_op_t                op;
    logic [ADDR_BITS-1:0]   addr;
    logic                   wdata;
    logic                   keepRow;  // Page mode: leave row open
  } mdi_req_t;

  typedef struct packed {
    logic                   rasN;
    logic                   casN;
    logic                   weN;
    logic [ROW_BITS-1:0]    addr;
    logic                   dataOut;
  } mdi_pins_t;

  // Gray-coded states along the usual path
  typedef enum logic [3:0] {
    S_IDLE  = 4'h0,
    S_ROW   = 4'h1,
    S_RCD   = 4'h3,
    S_CAS   = 4'h2,
    S_WLATE = 4'h6,
    S_END   = 4'h7,
    S_OPEN  = 4'h5,
    S_PRE   = 4'h4,
    S_REF   = 4'hC
  } mdi_state_t;

endpackage

//--- sim/mdi_dram_model.sv
// Behavioural 16K x 1 multiplexed-address dynamic memory
`timescale 1ns/100ps
module mdi_dram_model #(
  parameter realtime Q_DELAY = 10.0
) (
  // Strobes, address and data
  input  wire logic       rasN,
  input  wire logic       casN,
  input  wire logic       weN,
  input  wire logic [6:0] addr,
  input  wire logic       d,
  output      logic       q
);
  // --------------------------------------------------------------------
  // Cell array and strobe handling
  // --------------------------------------------------------------------
  logic       mem [16384];
  logic [6:0] row;
  logic [6:0] col;
  logic       casSeen = 1'b1;
  int         rasFalls = 0;
  int         refCount = 0;
  realtime    refAt [128];
  initial begin
    q = 1'b0;
    foreach (refAt[r]) refAt[r] = 0.0;
  end
  // Row half taken at row strobe fall; any such cycle refreshes
  always @(negedge rasN) begin
    row = addr;
    casSeen = 1'b0;
    rasFalls++;
    refAt[addr] = $realtime;
  end
  always @(posedge rasN) if (!casSeen) refCount++;
  // Column half; ignored without row strobe, as a deselect
  always @(negedge casN) if (!rasN) begin
    col = addr;
    casSeen = 1'b1;
    if (!weN) begin
      mem[{row, addr}] = d;
      q = ~q;
    end else
      q <= #(Q_DELAY) mem[{row, addr}];
  end
  // Delayed write: enable falling last takes the data
  always @(negedge weN)
    if (!rasN && !casN) mem[{row, col}] = d;
  // Released output shows the inverse, never a held level
  always @(posedge casN) q = ~q;
endmodule

//--- sim/mdi_host_bench.sv
// Self-checking bench for the DRAM host controller
`timescale 1ns/100ps
module mdi_host_bench;
  logic               core_clk;
  logic               rstn;
  logic               reqValid;
  mdi_pkg::mdi_req_t  req;
  logic               reqReady;
  logic               rspValid;
  logic               rspData;
  logic               initDone;
  logic               memQ;
  logic               rsp;
  mdi_pkg::mdi_pins_t pins;
  int                 failures = 0;
  int                 check_count = 0;
  int                 cycles = 0;
  mdi_host i_dut (.core_clk(core_clk), .rstn(rstn), .reqValid(reqValid),
    .req(req), .reqReady(reqReady), .rspValid(rspValid),
    .rspData(rspData), .initDone(initDone), .pins(pins), .memQ(memQ));
  // Slow answer: design must wait out the access time
  mdi_dram_model #(.Q_DELAY(30.0)) i_mem (.rasN(pins.rasN),
    .casN(pins.casN), .weN(pins.weN), .addr(pins.addr),
    .d(pins.dataOut), .q(memQ));
  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  always #20 core_clk = ~core_clk;
  task automatic print_verdict();
    if (failures == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check_bit(string name, logic exp, logic got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %b seen %b", name, exp, got);
    end
  endtask
  // One request, held until taken, then wait for its response
  task automatic access(mdi_pkg::mdi_op_t op,
                        logic [mdi_pkg::ADDR_BITS-1:0] a, logic w,
                        logic keep);
    int n;
    @(negedge core_clk);
    reqValid = 1'b1;
    req = '{op: op, addr: a, wdata: w, keepRow: keep};
    for (n = 0; reqReady !== 1'b1 && n < 2000; n++) @(negedge core_clk);
    @(negedge core_clk);
    reqValid = 1'b0;
    for (n = 0; rspValid !== 1'b1 && n < 100; n++) @(negedge core_clk);
    check_bit("rspValid", 1'b1, rspValid);
    rsp = rspData;
  endtask
  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic test_init();
    int n;
    for (n = 0; initDone !== 1'b1 && n < 3000; n++) @(negedge core_clk);
    check_bit("initDone", 1'b1, initDone);
    check_bit("warmup", 1'b1, i_mem.rasFalls >= 8);
  endtask
  // Corners and row-only or column-only differences
  task automatic test_cells();
    logic [13:0] a [6] = '{14'h0000, 14'h3FFF, 14'h0001, 14'h0080,
                          14'h2A55, 14'h15AA};
    for (int i = 0; i < 6; i++) begin
      access(mdi_pkg::MDI_OP_WRITE, a[i], i[0], 1'b0);
      check_bit("cell", i[0], i_mem.mem[a[i]]);
    end
    for (int i = 0; i < 6; i++) begin
      access(mdi_pkg::MDI_OP_READ, a[i], 1'b0, 1'b0);
      check_bit("rspData", i[0], rsp);
    end
  endtask
  task automatic test_rmw();
    access(mdi_pkg::MDI_OP_WRITE, 14'h1234, 1'b1, 1'b0);
    access(mdi_pkg::MDI_OP_RMW, 14'h1234, 1'b0, 1'b0);
    check_bit("rmwOld", 1'b1, rsp);
    check_bit("rmwNew", 1'b0, i_mem.mem[14'h1234]);
  endtask
  // Starts just after a refresh so none splits the page
  task automatic test_page();
    int n;
    int f;
    f = i_mem.refCount;
    for (n = 0; i_mem.refCount == f && n < 1000; n++) @(negedge core_clk);
    f = i_mem.rasFalls;
    access(mdi_pkg::MDI_OP_WRITE, 14'h3F00, 1'b1, 1'b1);
    access(mdi_pkg::MDI_OP_RMW, 14'h3F01, 1'b1, 1'b1);
    access(mdi_pkg::MDI_OP_READ, 14'h3F00, 1'b0, 1'b1);
    check_bit("pageRead", 1'b1, rsp);
    access(mdi_pkg::MDI_OP_READ, 14'h3F01, 1'b0, 1'b0);
    check_bit("pageRmw", 1'b1, rsp);
    check_bit("oneRow", 1'b1, i_mem.rasFalls == f + 1);
    // Page miss: a request for another row closes the open one
    access(mdi_pkg::MDI_OP_WRITE, 14'h3F00, 1'b1, 1'b1);
    access(mdi_pkg::MDI_OP_READ, 14'h0080, 1'b0, 1'b0);
    check_bit("otherRow", 1'b1, rsp);
  endtask
  // Idle for the full refresh period, then every row must be fresh
  task automatic test_refresh();
    logic ok;
    ok = 1'b1;
    repeat (50000) @(negedge core_clk);
    for (int r = 0; r < 128; r++)
      if ($realtime - i_mem.refAt[r] > 2.0e6) ok = 1'b0;
    check_bit("refreshAll", 1'b1, ok);
  endtask
  // Hang guard, well above the longest expected run
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 70000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    core_clk = 1'b0;
    rstn = 1'b0;
    reqValid = 1'b0;
    req = '0;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rstn = 1'b1;
    test_init();
    test_cells();
    test_rmw();
    test_page();
    test_refresh();
    print_verdict();
  end
endmodule
bind mdi_host mdi_host_monitor i_mon (.core_clk(core_clk), .rstn(rstn),
  .reqValid(reqValid), .req(req), .reqReady(reqReady),
  .rspValid(rspValid), .rspData(rspData), .initDone(initDone),
  .pins(pins), .memQ(memQ));

//--- sim/mdi_host_monitor.sv
// Checker on the pins and user port of the DRAM host controller
`timescale 1ns/100ps
module mdi_host_monitor (
  // Clock and reset
  input wire logic               core_clk,
  input wire logic               rstn,
  // User side
  input wire logic               reqValid,
  input wire mdi_pkg::mdi_req_t  req,
  input wire logic               reqReady,
  input wire logic               rspValid,
  input wire logic               rspData,
  input wire logic               initDone,
  // Memory side
  input wire mdi_pkg::mdi_pins_t pins,
  input wire logic               memQ
);
  // --------------------------------------------------------------------
  // Helper counters
  // --------------------------------------------------------------------
  // Slack covers a user cycle that delays a due refresh
  localparam logic [15:0] GAP_MAX = 16'(mdi_pkg::REF_INTERVAL_CYC + 40);
  logic        rasPrev_q;
  logic        rasFall;
  logic [15:0] gap_q;
  logic [15:0] gap_d;
  logic [3:0]  falls_q;
  logic [3:0]  falls_d;
  // Row strobe falls: spacing, and count before ready
  always_comb begin
    rasFall = rasPrev_q & ~pins.rasN;
    gap_d   = rasFall ? 16'h0000 : gap_q + {15'h0000, ~&gap_q};
    falls_d = falls_q + {3'h0, rasFall & ~initDone & ~&falls_q};
  end
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rasPrev_q <= 1'b1;
      gap_q     <= 16'h0000;
      falls_q   <= 4'h0;
    end else begin
      rasPrev_q <= pins.rasN;
      gap_q     <= gap_d;
      falls_q   <= falls_d;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_ready_needs_init: assert property (reqReady |-> initDone)
    else $error("request accepted before warm-up ended");
  a_init_eight_refresh: assert property (
    $rose(initDone) |-> falls_q == 4'h8)
    else $error("warm-up did not run eight row cycles");
  a_cas_inside_ras: assert property (!pins.casN |-> !pins.rasN)
    else $error("column strobe low without row strobe");
  a_row_addr_held: assert property (
    $fell(pins.rasN) |-> $stable(pins.addr))
    else $error("address moved at row strobe fall");
  a_col_addr_held: assert property (
    $fell(pins.casN) |-> $stable(pins.addr))
    else $error("address moved at column strobe fall");
  a_col_after_row: assert property (
    $fell(pins.casN) |-> !$past(pins.rasN, 2))
    else $error("column strobe too soon after row strobe");
  a_early_data_held: assert property (
    $fell(pins.casN) && !pins.weN |-> $stable(pins.dataOut))
    else $error("write data not settled at column strobe");
  a_we_inside_ras: assert property (!pins.weN |-> !pins.rasN)
    else $error("write enable low outside row strobe");
  a_rsp_at_cas_end: assert property ($rose(pins.casN) |-> rspValid)
    else $error("no response at end of column cycle");
  a_refresh_gap: assert property (initDone |-> gap_q < GAP_MAX)
    else $error("row strobe idle beyond refresh spacing");
endmodule
